/* File: verilog/mtx_map.svh */
`ifndef MTX_MAP_SVH
`define MTX_MAP_SVH

// register byte offsets
`define MTX_OFS_OUTCOME 12'h004
`define MTX_OFS_FILTER 12'h00C
`define MTX_OFS_COLL_CNT 12'h010
`define MTX_OFS_IRQ_STAT 12'h014
`define MTX_OFS_IRQ_EN 12'h018
`define MTX_OFS_IRQ_CLR 12'h01C
`define MTX_OFS_STA_LO 12'h020
`define MTX_OFS_STA_HI 12'h024

// transmit outcome bit positions
`define MTX_OC_TX_OK 0
`define MTX_OC_COLLIDED 2
`define MTX_OC_GAVE_UP 3
`define MTX_OC_CARRIER_LOST 4
`define MTX_OC_UNDERRUN 5
`define MTX_OC_HB_MISSING 6
`define MTX_OC_LATE_COLL 7

// interrupt status bit positions
`define MTX_IRQ_TX_DONE 0
`define MTX_IRQ_TX_ERR 1
`define MTX_IRQ_RX_ACCEPT 2
`define MTX_IRQ_RX_REJECT 3

// reset values
`define MTX_RST_OUTCOME 8'h00
`define MTX_RST_FILTER 6'h00
`define MTX_RST_IRQ 4'h0
`define MTX_RST_STATION 48'h0000_0000_0000

// timing and counts
`define MTX_CLK_MHZ 200
`define MTX_SLOT_NS 51200
`define MTX_HB_WINDOW_NS 6400
`define MTX_ATTEMPT_MAX 16
`define MTX_MIN_FRAME_LEN 16'h0040
`define MTX_RUNT_MIN_LEN 16'h0008

`endif

/* File: verilog/mtx_pkg.sv */
package mtx_pkg;

    typedef logic [47:0] mtx_mac_t;

    typedef struct packed {
        logic check_without_store;
        logic any_unicast_accept;
        logic multicast_hash_enable;
        logic broadcast_accept;
        logic runt_accept;
        logic keep_errored_frames;
    } mtx_rx_cfg_t;

    typedef enum logic [1:0] {
        MTX_TX_IDLE = 2'b00,
        MTX_TX_SYNC = 2'b01,
        MTX_TX_DATA = 2'b10,
        MTX_TX_GAP = 2'b11
    } mtx_tx_state_t;

endpackage

/* File: verilog/mtx_filt_if.sv */
`timescale 1ns/10ps
interface mtx_filt_if;
    import mtx_pkg::*;
    mtx_rx_cfg_t cfg;
    mtx_mac_t station_addr;
    mtx_mac_t dest_addr;
    logic [15:0] byte_count;
    logic crc_err;
    logic align_err;
    logic hash_hit;
    logic accept;

    modport owner (
        output cfg, station_addr, dest_addr, byte_count, crc_err, align_err, hash_hit,
        input accept
    );
    modport judge (
        input cfg, station_addr, dest_addr, byte_count, crc_err, align_err, hash_hit,
        output accept
    );
endinterface

/* File: verilog/mtx_rx_filter.sv */
`timescale 1ns/10ps
`include "mtx_map.svh"
module mtx_rx_filter (
    mtx_filt_if.judge fi
);
    import mtx_pkg::*;

    wire is_broadcast = &fi.dest_addr;
    wire is_multicast = fi.dest_addr[40] & ~is_broadcast;
    wire station_hit = fi.dest_addr == fi.station_addr;
    wire bcast_ok = is_broadcast & fi.cfg.broadcast_accept; // R12 R16
    wire mcast_ok = is_multicast & fi.cfg.multicast_hash_enable & fi.hash_hit; // R13 R16
    wire phys_ok = ~fi.dest_addr[40] & (fi.cfg.any_unicast_accept | station_hit); // R14
    wire addr_ok = bcast_ok | mcast_ok | phys_ok;
    wire errs_ok = fi.cfg.keep_errored_frames | ~(fi.crc_err | fi.align_err); // R10
    wire full_len = fi.byte_count >= `MTX_MIN_FRAME_LEN;
    wire runt_len = fi.byte_count >= `MTX_RUNT_MIN_LEN;
    wire len_ok = full_len | (fi.cfg.runt_accept & runt_len); // R11

    assign fi.accept = addr_ok & errs_ok & len_ok;
endmodule

/* File: verilog/mtx_top.sv */
// Behaviour
// [R1] host starting a transmission clears the whole outcome register
// [R2] tx_ok set only when frame ends without give-up or underrun; an underrun in the frame's last cycle still gets tx_ok
// [R3] collided set on any collision; count kept in collision count register
// [R4] sixteenth attempt ending in collision aborts and sets tx_gave_up
// [R5] carrier watched from end of sync until enable falls; loss flagged, no abort
// [R6] fifo empty without bus grant sets underrun flag and aborts frame
// [R7] no collision start within 6.4 us of gap sets heartbeat_missing
// [R8] collision after 51.2 us slot sets late_collision, handled as normal collision
// [R9] software reads outcome after each frame; undefined before first one
// [R10] keep_errored_frames clear rejects crc and alignment errors, set accepts
// [R11] runt_accept lets frames of 8 to 63 bytes pass
// [R12] broadcast_accept gates all-ones destination frames
// [R13] multicast passes only with hash enable and hash array hit
// [R14] physical address must match station unless any_unicast_accept set
// [R15] check mode stores nothing and counts each recognised frame as missed
// [R16] broadcast and multicast acceptance combine as a logical or
// [R17] full promiscuity needs both accepts, any-unicast and all-ones hash
// [R18] reserved outcome bits read zero, reserved filter bits ignore writes
`timescale 1ns/10ps
`include "mtx_map.svh"
module mtx_top #(
    parameter int SLOT_CYCLES = `MTX_SLOT_NS * `MTX_CLK_MHZ / 1000,
    parameter int HB_CYCLES = `MTX_HB_WINDOW_NS * `MTX_CLK_MHZ / 1000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit side
    input wire logic tx_start,
    input wire logic tx_request,
    input wire logic preamble_done,
    input wire logic carrier_sense,
    input wire logic collision_det,
    input wire logic fifo_empty,
    input wire logic bus_granted,
    output logic transmit_enable_out,
    output logic tx_abort,
    // receive side
    input wire logic rx_frame_done,
    input wire mtx_pkg::mtx_mac_t rx_dest_addr,
    input wire logic [15:0] rx_byte_count,
    input wire logic rx_crc_err,
    input wire logic rx_align_err,
    input wire logic rx_hash_hit,
    output logic rx_store,
    output logic rx_reject,
    output logic missed_tally_inc,
    // interrupt
    output logic irq
);
    import mtx_pkg::*;

    localparam int SW = $clog2(SLOT_CYCLES + 1);
    localparam int HW = $clog2(HB_CYCLES + 1);
    localparam logic [SW-1:0] SLOT_LIM = SW'(SLOT_CYCLES);
    localparam logic [HW-1:0] HB_LIM = HW'(HB_CYCLES);
    localparam logic [4:0] ATT_MAX = 5'(`MTX_ATTEMPT_MAX);

    // registers
    logic [7:0] outcome_q;
    logic [7:0] outcome_d;
    mtx_rx_cfg_t filter_q;
    logic [4:0] coll_cnt_q;
    logic [4:0] coll_cnt_d;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_stat_d;
    logic [3:0] irq_en_q;
    mtx_mac_t station_q;
    mtx_tx_state_t state_q;
    mtx_tx_state_t state_d;
    logic [SW-1:0] slot_cnt_q;
    logic [HW-1:0] hb_cnt_q;
    logic coll_prev_q;
    logic abort_hold_q;
    logic transmit_enable_out_q;
    logic tx_abort_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic rx_store_q;
    logic rx_reject_q;
    logic missed_q;
    logic irq_q;

    // apb decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_q;
    wire wr = access & pwrite;
    wire sel_outcome = paddr == `MTX_OFS_OUTCOME;
    wire sel_filter = paddr == `MTX_OFS_FILTER;
    wire sel_coll = paddr == `MTX_OFS_COLL_CNT;
    wire sel_stat = paddr == `MTX_OFS_IRQ_STAT;
    wire sel_en = paddr == `MTX_OFS_IRQ_EN;
    wire sel_clr = paddr == `MTX_OFS_IRQ_CLR;
    wire sel_sta_lo = paddr == `MTX_OFS_STA_LO;
    wire sel_sta_hi = paddr == `MTX_OFS_STA_HI;
    wire mapped = sel_outcome | sel_filter | sel_coll | sel_stat | sel_en | sel_clr
        | sel_sta_lo | sel_sta_hi;
    wire wr_filter = wr & sel_filter;
    wire wr_en = wr & sel_en;
    wire wr_clr = wr & sel_clr;
    wire wr_sta_lo = wr & sel_sta_lo;
    wire wr_sta_hi = wr & sel_sta_hi;

    wire [31:0] rd_mux =
        sel_outcome ? {24'h000000, outcome_q} :
        sel_coll ? {27'h0000000, coll_cnt_q} :
        sel_stat ? {28'h0000000, irq_stat_q} :
        sel_en ? {28'h0000000, irq_en_q} :
        sel_sta_lo ? station_q[31:0] :
        sel_sta_hi ? {16'h0000, station_q[47:32]} :
        32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // software owned settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filter_q <= mtx_rx_cfg_t'(`MTX_RST_FILTER);
            irq_en_q <= `MTX_RST_IRQ;
            station_q <= `MTX_RST_STATION;
        end
        else
        begin
            if (wr_filter)
                filter_q <= mtx_rx_cfg_t'(pwdata[5:0]); // R18
            if (wr_en)
                irq_en_q <= pwdata[3:0];
            if (wr_sta_lo)
                station_q[31:0] <= pwdata;
            if (wr_sta_hi)
                station_q[47:32] <= pwdata[15:0];
        end
    end

    // transmit event detection
    wire coll_rise = collision_det & ~coll_prev_q;
    wire in_attempt = (state_q == MTX_TX_SYNC) | (state_q == MTX_TX_DATA);
    wire attempt_coll = in_attempt & coll_rise;
    wire last_attempt = attempt_coll & (coll_cnt_q + 5'd1 == ATT_MAX); // R4
    wire late_coll = attempt_coll & (slot_cnt_q >= SLOT_LIM); // R8
    wire carrier_drop = (state_q == MTX_TX_DATA) & transmit_enable_out_q & ~carrier_sense; // R5
    wire underrun = (state_q == MTX_TX_DATA) & transmit_enable_out_q & fifo_empty & ~bus_granted; // R6
    wire abort_now = last_attempt | underrun;
    wire frame_end = (state_q == MTX_TX_DATA) & ~tx_request & ~coll_rise;
    wire hb_seen = (state_q == MTX_TX_GAP) & coll_rise;
    wire hb_timeout = (state_q == MTX_TX_GAP) & ~coll_rise & (hb_cnt_q >= HB_LIM);
    wire transmit_enable_out_rise = tx_request & ~transmit_enable_out_q & ~abort_hold_q & (state_q == MTX_TX_IDLE);
    wire tx_done_evt = frame_end | abort_now;
    wire tx_err_evt = abort_now | hb_timeout;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            MTX_TX_IDLE:
                if (transmit_enable_out_rise)
                    state_d = MTX_TX_SYNC;
            MTX_TX_SYNC:
                if (attempt_coll | ~tx_request)
                    state_d = MTX_TX_IDLE;
                else if (preamble_done)
                    state_d = MTX_TX_DATA;
            MTX_TX_DATA:
                if (attempt_coll | abort_now)
                    state_d = MTX_TX_IDLE;
                else if (frame_end)
                    state_d = MTX_TX_GAP;
            MTX_TX_GAP:
                if (hb_seen | hb_timeout)
                    state_d = MTX_TX_IDLE;
        endcase
    end

    // outcome bits; a set in the start cycle survives the clear
    always_comb
    begin
        outcome_d = tx_start ? 8'h00 : outcome_q; // R1
        if (frame_end & ~outcome_q[`MTX_OC_GAVE_UP] & ~outcome_q[`MTX_OC_UNDERRUN])
            outcome_d[`MTX_OC_TX_OK] = 1'b1; // R2
        if (attempt_coll)
            outcome_d[`MTX_OC_COLLIDED] = 1'b1; // R3
        if (last_attempt)
            outcome_d[`MTX_OC_GAVE_UP] = 1'b1; // R4
        if (carrier_drop)
            outcome_d[`MTX_OC_CARRIER_LOST] = 1'b1; // R5
        if (underrun)
            outcome_d[`MTX_OC_UNDERRUN] = 1'b1; // R6
        if (hb_timeout)
            outcome_d[`MTX_OC_HB_MISSING] = 1'b1; // R7
        if (late_coll)
            outcome_d[`MTX_OC_LATE_COLL] = 1'b1; // R8
        outcome_d[1] = 1'b0; // R18
    end

    always_comb
    begin
        coll_cnt_d = tx_start ? 5'd0 : coll_cnt_q;
        if (attempt_coll)
            coll_cnt_d = coll_cnt_d + 5'd1; // R3
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= MTX_TX_IDLE;
            outcome_q <= `MTX_RST_OUTCOME;
            coll_cnt_q <= 5'd0;
            coll_prev_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            outcome_q <= outcome_d;
            coll_cnt_q <= coll_cnt_d;
            coll_prev_q <= collision_det;
        end
    end

    // slot and heartbeat window timers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_cnt_q <= '0;
            hb_cnt_q <= '0;
        end
        else
        begin
            if (state_q == MTX_TX_IDLE)
                slot_cnt_q <= '0;
            else if (slot_cnt_q != SLOT_LIM)
                slot_cnt_q <= slot_cnt_q + SW'(1); // R8
            if (state_q != MTX_TX_GAP)
                hb_cnt_q <= HW'(1);
            else if (hb_cnt_q != HB_LIM)
                hb_cnt_q <= hb_cnt_q + HW'(1); // R7
        end
    end

    // transmit enable and abort
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transmit_enable_out_q <= 1'b0;
            abort_hold_q <= 1'b0;
            tx_abort_q <= 1'b0;
        end
        else
        begin
            transmit_enable_out_q <= tx_request & ~abort_hold_q & ~abort_now & ~(attempt_coll & ~tx_request);
            abort_hold_q <= (abort_hold_q | abort_now) & tx_request; // R4 R6
            tx_abort_q <= abort_now;
        end
    end

    // receive filter
    mtx_filt_if fi ();

    assign fi.cfg = filter_q;
    assign fi.station_addr = station_q;
    assign fi.dest_addr = rx_dest_addr;
    assign fi.byte_count = rx_byte_count;
    assign fi.crc_err = rx_crc_err;
    assign fi.align_err = rx_align_err;
    assign fi.hash_hit = rx_hash_hit;

    mtx_rx_filter u_filter (
        .fi(fi)
    );

    wire rx_ok = rx_frame_done & fi.accept;
    wire rx_bad = rx_frame_done & ~fi.accept;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_store_q <= 1'b0;
            rx_reject_q <= 1'b0;
            missed_q <= 1'b0;
        end
        else
        begin
            rx_store_q <= rx_ok & ~filter_q.check_without_store; // R15
            rx_reject_q <= rx_bad;
            missed_q <= rx_ok & filter_q.check_without_store; // R15
        end
    end

    // interrupt status, set beats clear
    wire [3:0] irq_evt = {rx_bad, rx_ok, tx_err_evt, tx_done_evt};
    wire [3:0] irq_clr = wr_clr ? pwdata[3:0] : 4'h0;

    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_q <= `MTX_RST_IRQ;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_en_q);
        end
    end

    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign transmit_enable_out = transmit_enable_out_q;
    assign tx_abort = tx_abort_q;
    assign rx_store = rx_store_q;
    assign rx_reject = rx_reject_q;
    assign missed_tally_inc = missed_q;
    assign irq = irq_q;
endmodule

/* File: tb/mtx_assertions.sv */
`timescale 1ns/10ps
`include "mtx_map.svh"
module mtx_assertions #(
    parameter int SLOT_CYCLES = 64,
    parameter int HB_CYCLES = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // transmit and receive
    input wire logic tx_request,
    input wire logic tx_abort,
    input wire logic transmit_enable_out,
    input wire logic rx_frame_done,
    input wire logic rx_store,
    input wire logic rx_reject,
    input wire logic missed_tally_inc
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_one_result;
        $onehot({rx_store, rx_reject, missed_tally_inc});
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_hole_gives_err: assert property (s_setup ##0 (paddr == 12'h008) |=> pslverr)
        else $error("unmapped access not refused");
    a_filter_no_err: assert property (s_setup ##0 (paddr == `MTX_OFS_FILTER) |=> !pslverr)
        else $error("filter access refused");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    a_rx_one_result: assert property (rx_frame_done |=> s_one_result)
        else $error("frame verdict not unique");
    a_rx_no_stray: assert property (!rx_frame_done |=> !(rx_store || rx_reject || missed_tally_inc))
        else $error("verdict without frame");
    a_enable_drops: assert property (!tx_request |=> !transmit_enable_out)
        else $error("enable without request");
    a_abort_pulse: assert property (tx_abort |=> !tx_abort)
        else $error("abort longer than a pulse");
endmodule
bind mtx_top mtx_assertions #(.SLOT_CYCLES(SLOT_CYCLES), .HB_CYCLES(HB_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_request(tx_request),
    .tx_abort(tx_abort), .transmit_enable_out(transmit_enable_out),
    .rx_frame_done(rx_frame_done), .rx_store(rx_store), .rx_reject(rx_reject),
    .missed_tally_inc(missed_tally_inc)
);

/* File: tb/mtx_phy_model.sv */
`timescale 1ns/10ps
module mtx_phy_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // from the device and the scenario
    input wire logic transmit_enable_out,
    input wire logic coll_cmd,
    input wire logic drop_cmd,
    input wire logic hb_on,
    // to the device
    output logic carrier_sense,
    output logic collision_det
);
    logic en_q;
    logic [3:0] hb_q;
    // carrier echoes own transmission unless a loss is staged
    assign carrier_sense = transmit_enable_out && !drop_cmd;
    // heartbeat burst early in the gap
    assign collision_det = coll_cmd || (hb_q > 4'h1 && hb_q < 4'h6);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            en_q <= 1'b0;
            hb_q <= 4'h0;
        end
        else
        begin
            en_q <= transmit_enable_out;
            if (en_q && !transmit_enable_out && hb_on)
                hb_q <= 4'h1;
            else if (hb_q != 4'h0)
                hb_q <= hb_q + 4'h1;
        end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`include "mtx_map.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module testbench;
    import mtx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tx_start, tx_request, preamble_done, carrier_sense, collision_det;
    logic fifo_empty, bus_granted, transmit_enable_out, tx_abort, irq;
    logic rx_frame_done, rx_crc_err, rx_align_err, rx_hash_hit;
    logic rx_store, rx_reject, missed_tally_inc, coll_cmd, drop_cmd, hb_on;
    mtx_mac_t rx_dest_addr;
    logic [15:0] rx_byte_count;
    int errors, checked, aborts, n;
    mtx_top #(.SLOT_CYCLES(64), .HB_CYCLES(16)) u_mtx_top (.*);
    mtx_phy_model u_mtx_phy_model (.*);
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (tx_abort === 1'b1)
            aborts++;
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is sampled at the edge itself, before the design updates it
        @(posedge pclk);
        while (pready !== 1'b1 && k < 10)
        begin
            @(posedge pclk);
            k++;
        end
        if (k == 10)
        begin
            errors++;
            report_and_stop();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic start_tx();
        @(posedge pclk);
        tx_start <= 1'b1;
        @(posedge pclk);
        tx_start <= 1'b0;
    endtask
    task automatic attempt(input int dly, input logic c, input logic uf, input logic hb);
        hb_on <= hb;
        tx_request <= 1'b1;
        cyc(2);
        preamble_done <= 1'b1;
        cyc(1);
        preamble_done <= 1'b0;
        cyc(dly);
        coll_cmd <= c;
        fifo_empty <= uf;
        bus_granted <= !uf;
        cyc(1);
        coll_cmd <= 1'b0;
        fifo_empty <= 1'b0;
        bus_granted <= 1'b1;
        tx_request <= 1'b0;
        cyc(24);
    endtask
    task automatic expect_tx(input logic [7:0] oc, input logic [4:0] cn);
        apb(1'b0, `MTX_OFS_OUTCOME, 32'h0);
        `CHK("outcome", oc, rd[7:0])
        apb(1'b0, `MTX_OFS_COLL_CNT, 32'h0);
        `CHK("coll count", cn, rd[4:0])
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h008, 32'h0);
        `CHK("hole err", 1'b1, slv)
        apb(1'b0, `MTX_OFS_FILTER, 32'h0);
        `CHK("filter read", 32'h0, rd)
        apb(1'b1, `MTX_OFS_OUTCOME, 32'hFFFF_FFFF);
        apb(1'b0, `MTX_OFS_OUTCOME, 32'h0);
        `CHK("outcome rsvd", 32'h0, rd & 32'hFFFF_FF02)
        $display("test regs done");
    endtask
    task automatic t_ok_irq();
        start_tx();
        drop_cmd <= 1'b1;
        attempt(6, 1'b0, 1'b0, 1'b1);
        drop_cmd <= 1'b0;
        expect_tx(8'h11, 5'h00);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, `MTX_OFS_IRQ_EN, 32'h1);
        cyc(2);
        #1;
        `CHK("irq on", 1'b1, irq)
        apb(1'b0, `MTX_OFS_IRQ_STAT, 32'h0);
        `CHK("tx done", 1'b1, rd[0])
        apb(1'b1, `MTX_OFS_IRQ_CLR, 32'hF);
        cyc(2);
        #1;
        `CHK("irq off", 1'b0, irq)
        $display("test ok_irq done");
    endtask
    task automatic t_tx_faults();
        start_tx();
        attempt(6, 1'b0, 1'b0, 1'b0);
        expect_tx(8'h41, 5'h00);
        start_tx();
        attempt(70, 1'b1, 1'b0, 1'b0);
        attempt(4, 1'b0, 1'b0, 1'b1);
        expect_tx(8'h85, 5'h01);
        start_tx();
        n = aborts;
        repeat (16) attempt(4, 1'b1, 1'b0, 1'b0);
        expect_tx(8'h0C, 5'h10);
        `CHK("abort pulses", n + 1, aborts)
        start_tx();
        attempt(4, 1'b0, 1'b1, 1'b0);
        expect_tx(8'h20, 5'h00);
        `CHK("abort pulses", n + 2, aborts)
        $display("test tx_faults done");
    endtask
    task automatic rx_case(input logic [7:0] c, input int ds, input logic [15:0] len,
        input logic [1:0] e, input logic h, input logic [2:0] x);
        mtx_mac_t dst [4];
        dst = '{48'h02AA_BBCC_DDEE, 48'h02AA_BBCC_DDEF, 48'hFFFF_FFFF_FFFF,
            48'h0100_5E00_0001};
        apb(1'b1, `MTX_OFS_FILTER, {24'h0, c});
        @(posedge pclk);
        rx_frame_done <= 1'b1;
        rx_dest_addr <= dst[ds];
        rx_byte_count <= len;
        rx_crc_err <= e[0];
        rx_align_err <= e[1];
        rx_hash_hit <= h;
        @(posedge pclk);
        rx_frame_done <= 1'b0;
        #1;
        `CHK("rx verdict", x, {missed_tally_inc, rx_reject, rx_store})
    endtask
    task automatic t_rx();
        apb(1'b1, `MTX_OFS_STA_LO, 32'hBBCC_DDEE);
        apb(1'b1, `MTX_OFS_STA_HI, 32'h0000_02AA);
        rx_case(8'h00, 0, 16'h0040, 2'h0, 1'b0, 3'h1);
        rx_case(8'h00, 1, 16'h0040, 2'h0, 1'b0, 3'h2);
        rx_case(8'h10, 1, 16'h0040, 2'h0, 1'b0, 3'h1);
        rx_case(8'h00, 0, 16'h0040, 2'h1, 1'b0, 3'h2);
        rx_case(8'h00, 0, 16'h0040, 2'h3, 1'b0, 3'h2);
        rx_case(8'h01, 0, 16'h0040, 2'h3, 1'b0, 3'h1);
        rx_case(8'h00, 0, 16'h003F, 2'h0, 1'b0, 3'h2);
        rx_case(8'h02, 0, 16'h0008, 2'h0, 1'b0, 3'h1);
        rx_case(8'h02, 0, 16'h0007, 2'h0, 1'b0, 3'h2);
        rx_case(8'h00, 2, 16'h0040, 2'h0, 1'b0, 3'h2);
        rx_case(8'h04, 2, 16'h0040, 2'h0, 1'b0, 3'h1);
        rx_case(8'h08, 3, 16'h0040, 2'h0, 1'b1, 3'h1);
        rx_case(8'h08, 3, 16'h0040, 2'h0, 1'b0, 3'h2);
        rx_case(8'h04, 3, 16'h0040, 2'h0, 1'b1, 3'h2);
        rx_case(8'h0C, 2, 16'h0040, 2'h0, 1'b0, 3'h1);
        rx_case(8'h0C, 0, 16'h0040, 2'h0, 1'b0, 3'h1);
        rx_case(8'h1C, 1, 16'h0040, 2'h0, 1'b1, 3'h1);
        rx_case(8'h20, 0, 16'h0040, 2'h0, 1'b0, 3'h4);
        rx_case(8'h20, 0, 16'h0040, 2'h1, 1'b0, 3'h2);
        rx_case(8'hC0, 0, 16'h003F, 2'h0, 1'b0, 3'h2);
        apb(1'b0, `MTX_OFS_IRQ_STAT, 32'h0);
        `CHK("irq status all", 4'hF, rd[3:0])
        apb(1'b1, `MTX_OFS_IRQ_CLR, 32'hF);
        apb(1'b0, `MTX_OFS_IRQ_STAT, 32'h0);
        `CHK("irq status clear", 4'h0, rd[3:0])
        $display("test rx done");
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, tx_start, tx_request, preamble_done} = 7'h00;
        {fifo_empty, rx_frame_done, rx_crc_err, rx_align_err, rx_hash_hit} = 5'h00;
        {coll_cmd, drop_cmd, hb_on} = 3'h0;
        bus_granted = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        rx_dest_addr = 48'h0;
        rx_byte_count = 16'h0;
        errors = 0;
        checked = 0;
        aborts = 0;
        cyc(3);
        presetn <= 1'b1;
        t_regs();
        t_ok_irq();
        t_tx_faults();
        t_rx();
        report_and_stop();
    end
    initial
    begin
        cyc(50000);
        errors++;
        report_and_stop();
    end
endmodule
